// [hw/isj_pkg.sv]
// shared constants and types for the inc/dec/skip/jump execute core
`default_nettype none
package isj_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int unsigned WORD_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned PC_W = 12;
  localparam int unsigned OPC_W = 6;
  localparam int unsigned JOPC_W = 2;

  // ------------------------------------------------------------
  // field positions in the instruction word
  // ------------------------------------------------------------
  localparam int unsigned OPC_LSB = 8;
  localparam int unsigned JOPC_LSB = 12;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned FADDR_LSB = 0;
  localparam int unsigned JADDR_LSB = 0;

  // ------------------------------------------------------------
  // opcode encodings
  // ------------------------------------------------------------
  localparam logic [OPC_W-1:0] OPC_DEC_FILE = 6'h03;
  localparam logic [OPC_W-1:0] OPC_DEC_SKIP_NULL = 6'h0b;
  localparam logic [OPC_W-1:0] OPC_INC_FILE = 6'h0a;
  localparam logic [JOPC_W-1:0] JOPC_ABS_JUMP = 2'h3;
  localparam logic DEST_ACC = 1'h0;
  localparam logic DEST_FILE = 1'h1;

  // ------------------------------------------------------------
  // reset values and arithmetic constants
  // ------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RESET = 12'h000;
  localparam logic [PC_W-1:0] PC_STEP = 12'h001;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [DATA_W-1:0] DATA_NULL = 8'h00;
  localparam logic [FADDR_W-1:0] FADDR_RESET = 7'h00;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ISJ_ST_EXEC = 2'b01,
    ISJ_ST_NOP = 2'b10
  } isj_state_e;

  typedef struct packed {
    logic en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } isj_fwrite_s;

  typedef struct packed {
    logic dec_file;
    logic dec_skip;
    logic inc_file;
    logic abs_jump;
    logic dest;
    logic [FADDR_W-1:0] faddr;
    logic [PC_W-1:0] target;
  } isj_decode_s;

  typedef struct packed {
    isj_state_e st;
    logic nop_adv;
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] acc;
    logic null_flag;
    isj_fwrite_s fwr;
    logic retire;
    logic discard;
  } isj_core_s;
endpackage : isj_pkg
`default_nettype wire

// [hw/isj_file_regs.sv]
// file register array with one write port, a preload port and a read port
`default_nettype none
module isj_file_regs #(
  parameter int unsigned DW = isj_pkg::DATA_W,
  parameter int unsigned AW = isj_pkg::FADDR_W
) (
  input wire logic core_clk_i,
  input wire logic ld_en_i,
  input wire logic [AW-1:0] ld_addr_i,
  input wire logic [DW-1:0] ld_data_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [DW-1:0] mem [2**AW];

  // core write wins over preload on the same address
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    if (ld_en_i && !(wr_en_i && wr_addr_i == ld_addr_i)) begin
      mem[ld_addr_i] <= ld_data_i;
    end
  end

  // asynchronous read so read-modify-write fits one cycle
  assign rd_data_o = mem[rd_addr_i];
endmodule : isj_file_regs
`default_nettype wire

// [hw/isj_core.sv]
// execute core for file decrement, decrement-skip, increment and absolute jump
`default_nettype none
// Contract
// RL1: 000011 decodes as file decrement
// RL2: dest bit 0 to accumulator, 1 to file
// RL3: decrement sets null flag on zero, one cycle
// RL4: 001011 decrement-skip, null flag kept
// RL5: zero result discards next word, two cycles
// RL6: nonzero result runs next word, one cycle
// RL7: bit 7 dest, bits 6..0 file address
// RL8: top bits 11 load 12-bit jump target
// RL9: jump takes two cycles, flags kept
// RL10: 001010 increments file, dest as decoded
// RL11: increment wraps, null flag on zero, one cycle
// RL12: otherwise program counter advances by one
module isj_core (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [isj_pkg::WORD_W-1:0] instr_i,
  input wire logic file_ld_en_i,
  input wire logic [isj_pkg::FADDR_W-1:0] file_ld_addr_i,
  input wire logic [isj_pkg::DATA_W-1:0] file_ld_data_i,
  output logic [isj_pkg::PC_W-1:0] pc_o,
  output logic [isj_pkg::DATA_W-1:0] acc_o,
  output logic null_flag_o,
  output logic file_wr_en_o,
  output logic [isj_pkg::FADDR_W-1:0] file_wr_addr_o,
  output logic [isj_pkg::DATA_W-1:0] file_wr_data_o,
  output logic retire_o,
  output logic discard_o
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  function automatic isj_pkg::isj_decode_s decode(input logic [isj_pkg::WORD_W-1:0] w);
    isj_pkg::isj_decode_s d;
    d = '0;
    d.dec_file = w[isj_pkg::OPC_LSB +: isj_pkg::OPC_W] == isj_pkg::OPC_DEC_FILE; // RL1
    d.dec_skip = w[isj_pkg::OPC_LSB +: isj_pkg::OPC_W] == isj_pkg::OPC_DEC_SKIP_NULL; // RL4
    d.inc_file = w[isj_pkg::OPC_LSB +: isj_pkg::OPC_W] == isj_pkg::OPC_INC_FILE; // RL10
    d.abs_jump = w[isj_pkg::JOPC_LSB +: isj_pkg::JOPC_W] == isj_pkg::JOPC_ABS_JUMP; // RL8
    d.dest = w[isj_pkg::DEST_BIT]; // RL7
    d.faddr = w[isj_pkg::FADDR_LSB +: isj_pkg::FADDR_W]; // RL7
    d.target = w[isj_pkg::JADDR_LSB +: isj_pkg::PC_W]; // RL8
    return d;
  endfunction

  function automatic logic [isj_pkg::PC_W-1:0] pc_inc(input logic [isj_pkg::PC_W-1:0] p);
    return p + isj_pkg::PC_STEP;
  endfunction

  // ------------------------------------------------------------
  // state and datapath signals
  // ------------------------------------------------------------
  isj_pkg::isj_core_s s;
  isj_pkg::isj_core_s next_s;
  isj_pkg::isj_decode_s dc;
  logic [isj_pkg::DATA_W-1:0] fval;
  logic [isj_pkg::DATA_W-1:0] res;
  logic in_exec;
  logic wr_op;
  logic fwr_go;

  assign dc = decode(instr_i);
  assign in_exec = s.st == isj_pkg::ISJ_ST_EXEC;
  assign wr_op = dc.dec_file || dc.dec_skip || dc.inc_file;
  // no file write while the core is held in reset
  assign fwr_go = next_s.fwr.en && reset_n_i;

  // increment wraps from ff to 00 by plain width truncation
  assign res = dc.inc_file ? fval + isj_pkg::DATA_ONE : fval - isj_pkg::DATA_ONE; // RL1 RL11

  isj_file_regs #(
    .DW(isj_pkg::DATA_W),
    .AW(isj_pkg::FADDR_W)
  ) u_file_regs (
    .core_clk_i(core_clk_i),
    .ld_en_i(file_ld_en_i),
    .ld_addr_i(file_ld_addr_i),
    .ld_data_i(file_ld_data_i),
    .wr_en_i(fwr_go),
    .wr_addr_i(next_s.fwr.addr),
    .wr_data_i(next_s.fwr.data),
    .rd_addr_i(dc.faddr),
    .rd_data_o(fval)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.fwr.en = 1'b0;
    next_s.retire = 1'b0;
    next_s.discard = 1'b0;
    case (s.st)
      isj_pkg::ISJ_ST_EXEC: begin
        next_s.retire = 1'b1;
        // any word not decoded below just steps, so later ops can slot in
        next_s.pc = pc_inc(s.pc); // RL6 RL12
        if (wr_op) begin
          if (dc.dest == isj_pkg::DEST_FILE) begin
            next_s.fwr.en = 1'b1; // RL2
            next_s.fwr.addr = dc.faddr; // RL7
            next_s.fwr.data = res;
          end else begin
            next_s.acc = res; // RL2
          end
          // the skip form leaves the null flag alone
          if (!dc.dec_skip) begin
            next_s.null_flag = res == isj_pkg::DATA_NULL; // RL3 RL11
          end
          if (dc.dec_skip && res == isj_pkg::DATA_NULL) begin
            next_s.st = isj_pkg::ISJ_ST_NOP; // RL5
            next_s.nop_adv = 1'b1;
          end
        end else if (dc.abs_jump) begin
          next_s.pc = dc.target; // RL8
          next_s.st = isj_pkg::ISJ_ST_NOP; // RL9
          next_s.nop_adv = 1'b0;
        end
      end
      isj_pkg::ISJ_ST_NOP: begin
        // jump bubble holds the target, skip bubble steps over the word
        next_s.discard = 1'b1;
        next_s.st = isj_pkg::ISJ_ST_EXEC;
        if (s.nop_adv) begin
          next_s.pc = pc_inc(s.pc); // RL5
        end
      end
      default: begin
        next_s.st = isj_pkg::ISJ_ST_EXEC;
      end
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s.st <= isj_pkg::ISJ_ST_EXEC;
      s.nop_adv <= 1'b0;
      s.pc <= isj_pkg::PC_RESET;
      s.acc <= isj_pkg::ACC_RESET;
      s.null_flag <= 1'b0;
      s.fwr.en <= 1'b0;
      s.fwr.addr <= isj_pkg::FADDR_RESET;
      s.fwr.data <= isj_pkg::DATA_NULL;
      s.retire <= 1'b0;
      s.discard <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign pc_o = s.pc;
  assign acc_o = s.acc;
  assign null_flag_o = s.null_flag;
  assign file_wr_en_o = s.fwr.en;
  assign file_wr_addr_o = s.fwr.addr;
  assign file_wr_data_o = s.fwr.data;
  assign retire_o = s.retire;
  assign discard_o = s.discard;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  logic ex_dec;
  logic ex_dsk;
  logic ex_inc;
  logic ex_jmp;
  logic ex_other;
  assign ex_dec = in_exec && dc.dec_file;
  assign ex_dsk = in_exec && dc.dec_skip;
  assign ex_inc = in_exec && dc.inc_file;
  assign ex_jmp = in_exec && dc.abs_jump;
  assign ex_other = in_exec && !wr_op && !dc.abs_jump;

  sequence bubble_then_exec;
    s.st == isj_pkg::ISJ_ST_NOP ##1 s.st == isj_pkg::ISJ_ST_EXEC;
  endsequence

  sequence single_cycle;
    s.st == isj_pkg::ISJ_ST_EXEC && s.retire;
  endsequence

  dec_to_file_a: assert property (ex_dec && dc.dest |=> // RL1
      s.fwr.en && s.fwr.data == $past(fval) - isj_pkg::DATA_ONE)
    else $error("file decrement wrote wrong value");

  dest_to_acc_a: assert property (in_exec && wr_op && !dc.dest |=> // RL2
      !s.fwr.en && s.acc == ($past(dc.inc_file) ?
      $past(fval) + isj_pkg::DATA_ONE : $past(fval) - isj_pkg::DATA_ONE))
    else $error("accumulator destination not honoured");

  dec_null_flag_a: assert property (ex_dec |=> // RL3
      single_cycle and s.null_flag == ($past(fval) == isj_pkg::DATA_ONE))
    else $error("decrement null flag or timing wrong");

  skip_keeps_flag_a: assert property (ex_dsk |=> $stable(s.null_flag)) // RL4
    else $error("decrement-skip touched null flag");

  // skip antecedents look at the operand, so a broken subtractor still trips them
  skip_taken_a: assert property (ex_dsk && fval == isj_pkg::DATA_ONE |=> // RL5
      bubble_then_exec ##0 s.pc == $past(s.pc, 2) + isj_pkg::PC_STEP + isj_pkg::PC_STEP)
    else $error("zero result did not discard next word");

  skip_not_taken_a: assert property (ex_dsk && fval != isj_pkg::DATA_ONE |=> // RL6
      single_cycle ##0 s.pc == $past(s.pc) + isj_pkg::PC_STEP)
    else $error("nonzero skip did not run next word");

  file_addr_a: assert property (in_exec && wr_op && dc.dest |=> // RL7
      s.fwr.addr == $past(instr_i[isj_pkg::FADDR_W-1:0]))
    else $error("file address field misrouted");

  jump_target_a: assert property (ex_jmp |=> // RL8
      s.pc == $past(instr_i[isj_pkg::PC_W-1:0]))
    else $error("jump target not loaded");

  jump_two_cycle_a: assert property (ex_jmp |=> // RL9
      bubble_then_exec ##0 ($stable(s.pc) && s.null_flag == $past(s.null_flag, 2)))
    else $error("jump timing or flags wrong");

  inc_write_a: assert property (ex_inc |=> // RL10
      s.fwr.en == $past(dc.dest) &&
      (s.fwr.en ? s.fwr.data : s.acc) == $past(fval) + isj_pkg::DATA_ONE)
    else $error("increment result misplaced");

  inc_wrap_a: assert property (ex_inc && fval == 8'hff |=> // RL11
      single_cycle and s.null_flag)
    else $error("increment wrap did not set null flag");

  pc_advance_a: assert property (ex_other |=> // RL12
      s.pc == $past(s.pc) + isj_pkg::PC_STEP)
    else $error("program counter did not advance");

  // ------------------------------------------------------------
  // checks on bubbles, holds and pulses
  // ------------------------------------------------------------
  // bubbles must leave every result register alone
  sequence skip_bubble;
    s.st == isj_pkg::ISJ_ST_NOP && s.nop_adv;
  endsequence

  sequence jump_bubble;
    s.st == isj_pkg::ISJ_ST_NOP && !s.nop_adv;
  endsequence

  pulse_excl_a: assert property (!(s.retire && s.discard)) // RL5 RL9
    else $error("retire and discard high together");

  exec_retire_a: assert property (in_exec |=> s.retire && !s.discard) // RL12
    else $error("executed word did not retire");

  bubble_quiet_a: assert property (s.st == isj_pkg::ISJ_ST_NOP |=> // RL5 RL9
      s.discard && !s.retire && !s.fwr.en && $stable(s.acc) && $stable(s.null_flag))
    else $error("bubble cycle changed state");

  skip_bubble_a: assert property (skip_bubble |=> // RL5
      s.st == isj_pkg::ISJ_ST_EXEC && s.pc == $past(s.pc) + isj_pkg::PC_STEP)
    else $error("skip bubble did not step over word");

  jump_bubble_a: assert property (jump_bubble |=> // RL9
      s.st == isj_pkg::ISJ_ST_EXEC && $stable(s.pc))
    else $error("jump bubble moved program counter");

  acc_hold_a: assert property (!(in_exec && wr_op && !dc.dest) |=> $stable(s.acc)) // RL2
    else $error("accumulator changed without a write");

  flag_hold_a: assert property (!(ex_dec || ex_inc) |=> $stable(s.null_flag)) // RL4 RL9
    else $error("null flag changed without a flag op");

  write_source_a: assert property (!(in_exec && wr_op && dc.dest) |=> // RL2
      !s.fwr.en && $stable(s.fwr.addr) && $stable(s.fwr.data))
    else $error("file write without a file destination");

  dsk_write_a: assert property (ex_dsk |=> // RL4
      (s.fwr.en ? s.fwr.data : s.acc) == $past(fval) - isj_pkg::DATA_ONE)
    else $error("decrement-skip result misplaced");

  inc_flag_a: assert property (ex_inc |=> // RL11
      s.null_flag == ($past(fval) == ~isj_pkg::DATA_NULL))
    else $error("increment null flag wrong");

  jump_quiet_a: assert property (ex_jmp |=> // RL9
      !s.fwr.en && $stable(s.acc) && $stable(s.null_flag))
    else $error("jump wrote data or flags");

  other_quiet_a: assert property (ex_other |=> // RL12
      !s.fwr.en && $stable(s.acc) && $stable(s.null_flag))
    else $error("unhandled word changed state");

  skip_flag_kept_a: assert property (ex_dsk && fval == isj_pkg::DATA_ONE |=> // RL4
      ##1 s.null_flag == $past(s.null_flag, 2))
    else $error("skip bubble lost the null flag");
endmodule : isj_core
`default_nettype wire

// [verif/isj_core_test.sv]
// self-checking bench for the inc/dec/skip/jump execute core
`default_nettype none
module isj_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus, design and reference state
  // ----------------------------------------
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [isj_pkg::WORD_W-1:0] instr_i = 14'h0000;
  logic file_ld_en_i = 1'b0;
  logic [isj_pkg::FADDR_W-1:0] file_ld_addr_i = 7'h00;
  logic [isj_pkg::DATA_W-1:0] file_ld_data_i = 8'h00;
  logic [isj_pkg::PC_W-1:0] pc_o;
  logic [isj_pkg::DATA_W-1:0] acc_o, file_wr_data_o;
  logic [isj_pkg::FADDR_W-1:0] file_wr_addr_o;
  logic null_flag_o, file_wr_en_o, retire_o, discard_o;
  int err_total = 0;
  int n_tests = 0;
  int m_pc, m_acc, m_flag, m_ret, m_dis, m_wen, m_wa, m_wd, m_bub;
  int fmem [128];

  isj_core u_isj_core (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .instr_i(instr_i),
    .file_ld_en_i(file_ld_en_i), .file_ld_addr_i(file_ld_addr_i),
    .file_ld_data_i(file_ld_data_i), .pc_o(pc_o), .acc_o(acc_o), .null_flag_o(null_flag_o),
    .file_wr_en_o(file_wr_en_o), .file_wr_addr_o(file_wr_addr_o),
    .file_wr_data_o(file_wr_data_o), .retire_o(retire_o), .discard_o(discard_o));

  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------
  // comparisons
  // ----------------------------------------
  task automatic chk_pc(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic compare();
    chk_pc(pc_o, 12'(m_pc));
    chk_data(acc_o, 8'(m_acc));
    chk_bit(null_flag_o, m_flag[0]);
    chk_bit(file_wr_en_o, m_wen[0]);
    chk_data({1'b0, file_wr_addr_o}, 8'(m_wa));
    chk_data(file_wr_data_o, 8'(m_wd));
    chk_bit(retire_o, m_ret[0]);
    chk_bit(discard_o, m_dis[0]);
  endtask

  // ----------------------------------------
  // reference model, one edge per call
  // ----------------------------------------
  task automatic apply(input logic [13:0] w, input logic le, input logic [6:0] la,
      input logic [7:0] ldd);
    int op, a, v, r;
    instr_i = w;
    file_ld_en_i = le;
    file_ld_addr_i = la;
    file_ld_data_i = ldd;
    op = int'(w[13:8]);
    a = int'(w[6:0]);
    v = fmem[a];
    r = -1;
    m_ret = 0;
    m_dis = 0;
    m_wen = 0;
    if (m_bub != 0) begin
      m_dis = 1;
      if (m_bub == 1) m_pc = (m_pc + 1) & 'hfff;
      m_bub = 0;
    end else begin
      m_ret = 1;
      m_pc = (m_pc + 1) & 'hfff;
      if (w[13:12] == 2'h3) begin
        m_pc = int'(w[11:0]);
        m_bub = 2;
      end else if (op == 'h03) begin
        r = (v - 1) & 'hff;
        m_flag = (r == 0);
      end else if (op == 'h0b) begin
        r = (v - 1) & 'hff;
        if (r == 0) m_bub = 1;
      end else if (op == 'h0a) begin
        r = (v + 1) & 'hff;
        m_flag = (r == 0);
      end
      if (r >= 0 && w[7]) begin
        m_wen = 1;
        m_wa = a;
        m_wd = r;
      end else if (r >= 0) m_acc = r;
    end
    // a core write to the preloaded address wins
    if (le && !(m_wen != 0 && m_wa == int'(la))) fmem[la] = int'(ldd);
    if (m_wen != 0) fmem[m_wa] = m_wd;
  endtask

  task automatic cyc(input logic [13:0] w, input logic le, input logic [6:0] la,
      input logic [7:0] ldd);
    @(negedge core_clk_i);
    compare();
    apply(w, le, la, ldd);
  endtask

  task automatic do_reset();
    reset_n_i = 1'b0;
    file_ld_en_i = 1'b0;
    {m_pc, m_acc, m_flag, m_ret, m_dis, m_wen, m_wa, m_wd, m_bub} = '0;
    repeat (2) begin
      @(negedge core_clk_i);
      compare();
    end
    reset_n_i = 1'b1;
    apply(14'h0000, 1'b0, 7'h00, 8'h00);
  endtask

  // biased so zero results and wraps happen often
  function automatic logic [7:0] rnd_data();
    case ($urandom % 4)
      0: return 8'h01;
      1: return 8'hff;
      2: return 8'h00;
      default: return 8'($urandom);
    endcase
  endfunction
  function automatic logic [13:0] rnd_word();
    logic [5:0] ops [3];
    int k;
    ops = '{6'h03, 6'h0b, 6'h0a};
    k = $urandom % 5;
    if (k < 3) return {ops[k], 1'($urandom), 7'($urandom % 8)};
    return 14'($urandom);
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(60));
    foreach (fmem[i]) fmem[i] = 0;
    do_reset();
    for (int i = 0; i < 128; i++) cyc(14'h0000, 1'b1, 7'(i), rnd_data());
    $display("test preload done");
    repeat (3000) cyc(rnd_word(), ($urandom % 4) == 0, 7'($urandom % 8), rnd_data());
    $display("test random stream done");
    cyc(14'h0000, 1'b0, 7'h00, 8'h00);
    do_reset();
    cyc(14'h0000, 1'b1, 7'h03, 8'h01);
    cyc(14'h0000, 1'b1, 7'h04, 8'hff);
    cyc(14'h0000, 1'b1, 7'h05, 8'h01);
    cyc(14'h0b83, 1'b0, 7'h00, 8'h00);
    cyc(14'h3fff, 1'b0, 7'h00, 8'h00);
    cyc(14'h0b05, 1'b0, 7'h00, 8'h00);
    cyc(14'h3abc, 1'b0, 7'h00, 8'h00);
    cyc(14'h3fff, 1'b0, 7'h00, 8'h00);
    cyc(14'h3abc, 1'b0, 7'h00, 8'h00);
    cyc(14'h0a84, 1'b0, 7'h00, 8'h00);
    cyc(14'h0304, 1'b0, 7'h00, 8'h00);
    cyc(14'h3000, 1'b0, 7'h00, 8'h00);
    cyc(14'h0a04, 1'b0, 7'h00, 8'h00);
    cyc(14'h0b84, 1'b0, 7'h00, 8'h00);
    cyc(14'h0385, 1'b0, 7'h00, 8'h00);
    cyc(14'h0000, 1'b0, 7'h00, 8'h00);
    cyc(14'h0000, 1'b0, 7'h00, 8'h00);
    $display("test directed done");
    summarize();
  end
endmodule // isj_core_test
`default_nettype wire
